// file: design/tlv_regs.svh
`ifndef TLV_REGS_SVH
`define TLV_REGS_SVH

// word indices; byte address is four times the index
`define TLV_STS_IDX 10'h000
`define TLV_MSK_IDX 10'h001
`define TLV_DMSK_IDX 10'h002
`define TLV_ROUTE_IDX 10'h008
`define TLV_CTRL_A_IDX 10'h0DA
`define TLV_CTRL_B_IDX 10'h0DB

// fixed vectors of the direct processor inputs
`define TLV_VEC_NMI 16'h0024
`define TLV_VEC_HI 16'h003C
`define TLV_VEC_MID 16'h0034
`define TLV_VEC_LO 16'h002C

// control word fields
`define TLV_CW_INIT_BIT 4
`define TLV_CW_RD_BIT 3
`define TLV_CW_IVL8_BIT 2
`define TLV_OP_NESTED 3'h0
`define TLV_OP_EOI 3'h1
`define TLV_OP_ROTATE 3'h2
`define TLV_OP_SEOI 3'h3
`define TLV_OP_POLLED 3'h4
`define TLV_OP_SETPRI 3'h6

// reset values
`define TLV_RST_IMR 8'hFF
`define TLV_RST_DMSK 3'h7
`define TLV_RST_LOWEST 3'h7
`define TLV_RST_BASE 11'h000

`endif

// file: design/tlv_pkg.sv
package tlv_pkg;

  typedef enum logic [1:0] {
    MODE_NESTED,
    MODE_ROTATE,
    MODE_SPECIFIC,
    MODE_POLLED
  } tlv_mode_e;

  typedef enum logic [2:0] {
    SRC_NMI,
    SRC_HI,
    SRC_MID,
    SRC_LO,
    SRC_CTRL
  } tlv_src_e;

  typedef struct packed {
    logic valid;
    tlv_src_e src;
    logic [2:0] level;
    logic [15:0] vector;
  } tlv_sel_s;

endpackage

// file: design/tlv_vectoring.sv
// Summary of operation
// (R01) twelve levels; direct four outrank controller eight
// (R02) order: non-maskable, high, middle, low restart
// (R03) direct vectors 24H, 3CH, 34H, 2CH
// (R04) direct inputs maskable except non-maskable
// (R05) board designer routes power-down to non-maskable
// (R06) raise only if best pending outranks in-service
// (R07) one mask byte, bit per controller level
// (R08) vectors spaced 4 or 8 bytes, software chosen
// (R09) vector block placed on own-size boundary
// (R10) fully nested: line 0 highest, 7 lowest
// (R11) rotating: serviced level becomes lowest
// (R12) specific: software names lowest, rest follow
// (R13) polled: priority-encoded status readable
// (R14) mode and priorities changeable any time
// (R15) eighteen request sources accepted
// (R16) parallel buffer full/empty requests selectable
// (R17) serial receive/transmit requests selectable
// (R18) power-fail taken with mains-failure signal
// (R19) shared two addresses, order and bit select
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`include "tlv_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module tlv_vectoring
  import tlv_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // request pins, asynchronous
  input wire logic pwr_fail_req,
  input wire logic mains_fail_signal,
  input wire logic rst_hi_req,
  input wire logic rst_mid_req,
  input wire logic rst_lo_req,
  input wire logic [17:0] src_req,
  // processor core side
  input wire logic cpu_inta,
  output logic cpu_int,
  output logic [15:0] cpu_vector,
  output logic [2:0] cpu_src,
  // software interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [22:0] pin_meta_q;
  logic [22:0] pin_sync_q;
  logic [17:0] src_s;
  logic nmi_lvl;
  logic hi_s;
  logic mid_s;
  logic lo_s;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= {mains_fail_signal, pwr_fail_req, rst_hi_req, rst_mid_req, rst_lo_req,
                     src_req};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign src_s = pin_sync_q[17:0]; // [R15]
  assign lo_s = pin_sync_q[18];
  assign mid_s = pin_sync_q[19];
  assign hi_s = pin_sync_q[20];
  // a power-fail request counts only while the supply also reports mains failure
  assign nmi_lvl = pin_sync_q[21] & pin_sync_q[22]; // [R18]

  ////////////////////////////////////////////////////////////////////////////
  // bus front end

  logic wr_pend_q;
  logic [9:0] wr_idx_q;
  logic rd_req;
  logic [9:0] rd_idx;
  logic [31:0] rd_word;
  logic [31:0] hrdata_q;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign rd_req = hsel & htrans[1] & ~hwrite & hready;
  assign rd_idx = haddr[11:2];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= '0;
    end else if (hready) begin
      wr_pend_q <= hsel & htrans[1] & hwrite;
      wr_idx_q <= haddr[11:2];
    end
  end

  // read data is latched in the address phase so the data phase needs no wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= '0;
    end else if (rd_req) begin
      hrdata_q <= rd_word;
    end
  end

  logic wr_sts;
  logic wr_msk;
  logic wr_dmsk;
  logic wr_a;
  logic wr_b;
  logic rd_a;
  logic cmd_init;
  logic cmd_ocw;
  logic cmd_rd;
  logic [2:0] cmd_op;

  assign wr_sts = wr_pend_q && wr_idx_q == `TLV_STS_IDX;
  assign wr_msk = wr_pend_q && wr_idx_q == `TLV_MSK_IDX;
  assign wr_dmsk = wr_pend_q && wr_idx_q == `TLV_DMSK_IDX;
  assign wr_a = wr_pend_q && wr_idx_q == `TLV_CTRL_A_IDX;
  assign wr_b = wr_pend_q && wr_idx_q == `TLV_CTRL_B_IDX;
  assign rd_a = rd_req && rd_idx == `TLV_CTRL_A_IDX;
  // two data bits (4 and 3) of the word written to the first address pick its meaning
  assign cmd_init = wr_a & hwdata[`TLV_CW_INIT_BIT]; // [R19]
  assign cmd_rd = wr_a & ~hwdata[`TLV_CW_INIT_BIT] & hwdata[`TLV_CW_RD_BIT];
  assign cmd_ocw = wr_a & ~hwdata[`TLV_CW_INIT_BIT] & ~hwdata[`TLV_CW_RD_BIT];
  assign cmd_op = hwdata[7:5];

  ////////////////////////////////////////////////////////////////////////////
  // controller configuration

  tlv_mode_e mode_q;
  logic [2:0] lowest_q;
  logic [10:0] base_q;
  logic ivl8_q;
  logic init_pend_q;
  logic rdsel_isr_q;
  logic [7:0] imr_q;
  logic [2:0] dmask_q;
  logic [17:0] route_q [8];
  logic [2:0] svc_lvl;
  logic eoi_do;
  logic [2:0] eoi_lvl;

  // the second address takes the block address right after an init word, else the mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_pend_q <= 1'b0;
      base_q <= `TLV_RST_BASE;
      ivl8_q <= 1'b0;
    end else if (cmd_init) begin
      init_pend_q <= 1'b1; // [R19]
      base_q[2:0] <= hwdata[7:5];
      ivl8_q <= ~hwdata[`TLV_CW_IVL8_BIT]; // [R08]
    end else if (wr_b && init_pend_q) begin
      init_pend_q <= 1'b0;
      base_q[10:3] <= hwdata[7:0]; // [R09]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      imr_q <= `TLV_RST_IMR;
    end else if (wr_b && !init_pend_q) begin
      imr_q <= hwdata[7:0]; // [R07]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdsel_isr_q <= 1'b0;
    end else if (cmd_rd) begin
      rdsel_isr_q <= hwdata[0];
    end
  end

  // mode and rotation may be changed while requests are live; ranking follows at once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= MODE_NESTED;
      lowest_q <= `TLV_RST_LOWEST;
    end else if (cmd_ocw) begin // [R14]
      unique case (cmd_op)
        `TLV_OP_NESTED: begin
          mode_q <= MODE_NESTED;
          lowest_q <= `TLV_RST_LOWEST; // [R10]
        end
        `TLV_OP_ROTATE: begin
          mode_q <= MODE_ROTATE; // [R11]
        end
        `TLV_OP_POLLED: begin
          mode_q <= MODE_POLLED; // [R13]
        end
        `TLV_OP_SETPRI: begin
          mode_q <= MODE_SPECIFIC;
          lowest_q <= hwdata[2:0]; // [R12]
        end
        `TLV_OP_EOI, `TLV_OP_SEOI: begin
          if (mode_q == MODE_ROTATE && eoi_do) begin
            lowest_q <= eoi_lvl; // [R11]
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dmask_q <= `TLV_RST_DMSK;
    end else if (wr_dmsk) begin
      dmask_q <= hwdata[2:0]; // [R04]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request latching and ranking per level

  logic [7:0] irr_q;
  logic [7:0] isr_q;
  logic [7:0] routed;
  logic [7:0] routed_prev_q;
  logic [7:0] pend;
  logic [7:0] pend_rot;
  logic [7:0] isr_rot;
  logic ack_ctrl;
  logic [2:0] ack_lvl;
  logic poll_ack;

  assign pend = irr_q & ~imr_q; // [R07]

  for (genvar i = 0; i < 8; i++) begin : g_lvl
    // jumper routing of the sources (buffer full/empty, timers, bus lines) is a register
    assign routed[i] = |(route_q[i] & src_s); // [R16] [R17]

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        route_q[i] <= '0;
      end else if (wr_pend_q && wr_idx_q == `TLV_ROUTE_IDX + 10'(i)) begin
        route_q[i] <= hwdata[17:0]; // [R15]
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        routed_prev_q[i] <= 1'b0;
        irr_q[i] <= 1'b0;
      end else begin
        routed_prev_q[i] <= routed[i];
        // a new edge wins over an acknowledge of the same level
        if (routed[i] && !routed_prev_q[i]) begin
          irr_q[i] <= 1'b1;
        end else if ((ack_ctrl || poll_ack) && ack_lvl == 3'(i)) begin
          irr_q[i] <= 1'b0;
        end
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        isr_q[i] <= 1'b0;
      end else if ((ack_ctrl || poll_ack) && ack_lvl == 3'(i)) begin
        isr_q[i] <= 1'b1;
      end else if (eoi_do && eoi_lvl == 3'(i)) begin
        isr_q[i] <= 1'b0;
      end
    end

    // position k counts from the level just after the lowest one
    assign pend_rot[i] = pend[3'(lowest_q + 3'd1 + 3'(i))]; // [R12]
    assign isr_rot[i] = isr_q[3'(lowest_q + 3'd1 + 3'(i))];
  end

  logic [2:0] pk;
  logic [2:0] ik;
  logic pend_any;
  logic isr_any;
  logic ctrl_ok;

  always_comb begin
    pk = 3'd0;
    ik = 3'd0;
    for (int k = 7; k >= 0; k--) begin
      if (pend_rot[k]) begin
        pk = 3'(k);
      end
      if (isr_rot[k]) begin
        ik = 3'(k);
      end
    end
  end

  assign pend_any = |pend;
  assign isr_any = |isr_q;
  assign svc_lvl = lowest_q + 3'd1 + ik;
  // nested service: only a strictly better rank interrupts the one in service
  assign ctrl_ok = pend_any && (!isr_any || pk < ik); // [R06]
  assign eoi_do = cmd_ocw && ((cmd_op == `TLV_OP_EOI && isr_any) || cmd_op == `TLV_OP_SEOI);
  assign eoi_lvl = (cmd_op == `TLV_OP_SEOI) ? hwdata[2:0] : svc_lvl;
  // a poll read doubles as the acknowledge, as no processor cycle is involved
  assign poll_ack = rd_a && mode_q == MODE_POLLED && pend_any; // [R13]

  ////////////////////////////////////////////////////////////////////////////
  // twelve-level arbitration toward the processor

  logic nmi_prev_q;
  logic nmi_pend_q;
  logic nmi_edge;
  logic ack_nmi;
  tlv_sel_s sel;
  tlv_sel_s sel_q;
  logic [15:0] ctrl_vec;

  assign nmi_edge = nmi_lvl & ~nmi_prev_q;
  assign ack_nmi = cpu_inta && sel_q.valid && sel_q.src == SRC_NMI;
  assign ack_ctrl = cpu_inta && sel_q.valid && sel_q.src == SRC_CTRL;
  assign ack_lvl = poll_ack ? 3'(lowest_q + 3'd1 + pk) : sel_q.level;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nmi_prev_q <= 1'b0;
      nmi_pend_q <= 1'b0;
    end else begin
      nmi_prev_q <= nmi_lvl;
      if (nmi_edge) begin
        nmi_pend_q <= 1'b1;
      end else if (ack_nmi) begin
        nmi_pend_q <= 1'b0;
      end
    end
  end

  assign ctrl_vec = ivl8_q ? {base_q[10:1], 3'(lowest_q + 3'd1 + pk), 3'b000}
                           : {base_q, 3'(lowest_q + 3'd1 + pk), 2'b00}; // [R08] [R09]

  always_comb begin
    sel = '0;
    // the non-maskable input ignores every mask
    // the fresh edge counts at once, so a direct level synchronised in the same
    // cycle cannot take the offer ahead of the non-maskable input
    if (nmi_pend_q || nmi_edge) begin // [R02] [R04]
      sel = '{valid: 1'b1, src: SRC_NMI, level: 3'd0, vector: `TLV_VEC_NMI}; // [R03]
    end else if (hi_s && !dmask_q[2]) begin
      sel = '{valid: 1'b1, src: SRC_HI, level: 3'd0, vector: `TLV_VEC_HI};
    end else if (mid_s && !dmask_q[1]) begin
      sel = '{valid: 1'b1, src: SRC_MID, level: 3'd0, vector: `TLV_VEC_MID};
    end else if (lo_s && !dmask_q[0]) begin
      sel = '{valid: 1'b1, src: SRC_LO, level: 3'd0, vector: `TLV_VEC_LO};
    end else if (ctrl_ok && mode_q != MODE_POLLED) begin // [R01]
      sel = '{valid: 1'b1, src: SRC_CTRL, level: 3'(lowest_q + 3'd1 + pk), vector: ctrl_vec};
    end
  end

  // an offer stands until acknowledged, so the core never sees the vector move under it;
  // the edge that ends the acknowledge cycle drops the offer for a cycle so one request is not taken twice
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_q <= '0;
    end else if (cpu_inta) begin
      sel_q <= '0;
    end else if (!sel_q.valid) begin
      sel_q <= sel; // [R02]
    end
  end

  assign cpu_int = sel_q.valid;
  assign cpu_vector = sel_q.vector;
  assign cpu_src = sel_q.src;

  ////////////////////////////////////////////////////////////////////////////
  // software event flags

  logic [2:0] sts_q;
  logic [2:0] msk_q;
  logic [2:0] ev;

  assign ev = {cpu_inta & sel_q.valid, |(routed & ~routed_prev_q), nmi_edge};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sts_q <= '0;
    end else begin
      // a fresh event outlives a clear written in the same cycle
      sts_q <= (sts_q & ~(wr_sts ? hwdata[2:0] : 3'b000)) | ev;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      msk_q <= '0;
    end else if (wr_msk) begin
      msk_q <= hwdata[2:0];
    end
  end

  assign irq = |(sts_q & msk_q);

  ////////////////////////////////////////////////////////////////////////////
  // read multiplexer

  always_comb begin
    rd_word = '0;
    if (rd_idx == `TLV_STS_IDX) begin
      rd_word = {29'h0, sts_q};
    end else if (rd_idx == `TLV_MSK_IDX) begin
      rd_word = {29'h0, msk_q};
    end else if (rd_idx == `TLV_DMSK_IDX) begin
      rd_word = {29'h0, dmask_q};
    end else if (rd_idx == `TLV_CTRL_A_IDX) begin
      if (mode_q == MODE_POLLED) begin
        rd_word = {24'h0, pend_any, 4'h0, 3'(lowest_q + 3'd1 + pk)}; // [R13]
      end else begin
        rd_word = {24'h0, rdsel_isr_q ? isr_q : irr_q}; // [R19]
      end
    end else if (rd_idx == `TLV_CTRL_B_IDX) begin
      rd_word = {24'h0, imr_q};
    end else if (rd_idx >= `TLV_ROUTE_IDX && rd_idx < `TLV_ROUTE_IDX + 10'd8) begin
      rd_word = {14'h0, route_q[rd_idx[2:0]]};
    end
  end

endmodule

`default_nettype wire

// file: tb/tlv_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tlv_monitor
  import tlv_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // power pins
  input wire logic pwr_fail_req,
  input wire logic mains_fail_signal,
  // processor side
  input wire logic cpu_inta,
  input wire logic cpu_int,
  input wire logic [15:0] cpu_vector,
  input wire logic [2:0] cpu_src
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_offer_holds: assert property (
    cpu_int && !cpu_inta |=> cpu_int && $stable(cpu_vector) && $stable(cpu_src))
    else $error("offer changed before acknowledge");
  a_ack_drops_int: assert property (
    cpu_int && cpu_inta |=> !cpu_int)
    else $error("offer stayed after acknowledge");
  a_drop_needs_ack: assert property (
    $fell(cpu_int) |-> $past(cpu_inta))
    else $error("offer withdrawn without acknowledge");
  a_direct_vecs: assert property (
    cpu_int |-> (cpu_src != SRC_NMI || cpu_vector == 16'h0024)
      && (cpu_src != SRC_HI || cpu_vector == 16'h003C)
      && (cpu_src != SRC_MID || cpu_vector == 16'h0034)
      && (cpu_src != SRC_LO || cpu_vector == 16'h002C))
    else $error("direct vector wrong");
  a_ctrl_align: assert property (
    cpu_int && cpu_src == SRC_CTRL |-> cpu_vector[1:0] == 2'b00)
    else $error("controller vector misaligned");
  a_nmi_taken: assert property (
    $rose(pwr_fail_req && mains_fail_signal) && !cpu_int
      |-> ##[1:8] (cpu_int && cpu_src == SRC_NMI))
    else $error("power fail not offered");
  a_src_range: assert property (
    cpu_int |-> cpu_src <= 3'h4)
    else $error("source code out of range");
  a_bus_okay: assert property (
    hreadyout && !hresp)
    else $error("bus answer not ready okay");
  cover property (cpu_int && cpu_src == SRC_NMI);
  cover property (cpu_int && cpu_src == SRC_CTRL);
  cover property (cpu_int && cpu_inta);
endmodule
bind tlv_vectoring tlv_monitor u_mon (
  .hclk(hclk),
  .hresetn(hresetn),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .pwr_fail_req(pwr_fail_req),
  .mains_fail_signal(mains_fail_signal),
  .cpu_inta(cpu_inta),
  .cpu_int(cpu_int),
  .cpu_vector(cpu_vector),
  .cpu_src(cpu_src)
);
`default_nettype wire

// file: tb/tlv_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module tlv_cpu_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // offer and bench control
  input wire logic cpu_int,
  input wire logic ack_en,
  input wire logic [3:0] ack_wait,
  // acknowledge
  output var logic cpu_inta,
  output var logic [7:0] taken
);
  logic [3:0] wait_q;
  logic done_q;
  // one acknowledge per enable, so a standing level request is not swallowed unseen
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_inta <= 1'b0;
      taken <= 8'h00;
      wait_q <= 4'h0;
      done_q <= 1'b0;
    end else begin
      cpu_inta <= 1'b0;
      if (!ack_en) begin
        done_q <= 1'b0;
        wait_q <= 4'h0;
      end else if (!done_q && cpu_int && !cpu_inta) begin
        if (wait_q == ack_wait) begin
          cpu_inta <= 1'b1;
          taken <= taken + 8'h01;
          done_q <= 1'b1;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import tlv_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic [1:0] htrans;
  logic pwr_fail_req, mains_fail_signal, rst_hi_req, rst_mid_req, rst_lo_req;
  logic [17:0] src_req;
  logic cpu_inta, cpu_int, ack_en;
  logic [15:0] cpu_vector;
  logic [2:0] cpu_src;
  logic [3:0] ack_wait;
  logic [7:0] taken;
  int bad_count, checks, i;
  tlv_vectoring dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pwr_fail_req(pwr_fail_req), .mains_fail_signal(mains_fail_signal),
    .rst_hi_req(rst_hi_req), .rst_mid_req(rst_mid_req), .rst_lo_req(rst_lo_req),
    .src_req(src_req), .cpu_inta(cpu_inta), .cpu_int(cpu_int),
    .cpu_vector(cpu_vector), .cpu_src(cpu_src), .irq(irq));
  tlv_cpu_model cpu (.hclk(hclk), .hresetn(hresetn), .cpu_int(cpu_int), .ack_en(ack_en),
    .ack_wait(ack_wait), .cpu_inta(cpu_inta), .taken(taken));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [17:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {14'h0000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [17:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input string n, input logic [11:0] a, input logic [17:0] e);
    bus(1'b0, a, 18'h0_0000);
    chk(n, rdat, {14'h0000, e});
  endtask
  task automatic offer(input logic [15:0] v, input logic [2:0] s);
    // let the edge that ended the previous step settle before looking
    @(negedge hclk);
    for (int k = 0; k < 40 && cpu_int !== 1'b1; k++) @(negedge hclk);
    chk("vector", {16'h0000, cpu_vector}, {16'h0000, v});
    chk("source", {29'h0, cpu_src}, {29'h0, s});
  endtask
  task automatic quiet;
    logic seen = 1'b0;
    repeat (12) begin
      @(negedge hclk);
      seen |= cpu_int;
    end
    chk("idle", {31'h0, seen}, 32'h0000_0000);
  endtask
  task automatic ack;
    logic [7:0] t = taken;
    @(posedge hclk);
    ack_en <= 1'b1;
    for (int k = 0; k < 40 && taken === t; k++) @(negedge hclk);
    @(posedge hclk);
    ack_en <= 1'b0;
    chk("acks", {24'h0, taken}, {24'h0, t + 8'h01});
  endtask
  // acknowledge, then non-specific end of service
  task automatic serve;
    ack;
    wr(12'h368, 18'h0_0020);
  endtask
  // two low cycles first so the synchroniser sees a fresh rising edge
  task automatic raise(input logic [17:0] v);
    repeat (2) @(posedge hclk) src_req <= 18'h0_0000;
    @(posedge hclk) src_req <= v;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    final_report;
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, ack_en, src_req} = '0;
    {pwr_fail_req, mains_fail_signal, rst_hi_req, rst_mid_req, rst_lo_req} = 5'h00;
    {bad_count, checks, ack_wait} = {32'h0, 32'h0, 4'h3};
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd("direct mask", 12'h008, 18'h0_0007);
    rd("level mask", 12'h36C, 18'h0_00FF);
    rd("unmapped", 12'h3F0, 18'h0_0000);
    @(posedge hclk) {rst_hi_req, rst_mid_req, rst_lo_req} <= 3'h7;
    quiet;
    wr(12'h008, 18'h0_0000);
    offer(16'h003C, 3'h1);
    @(posedge hclk) rst_hi_req <= 1'b0;
    ack;
    offer(16'h0034, 3'h2);
    @(posedge hclk) rst_mid_req <= 1'b0;
    ack;
    offer(16'h002C, 3'h3);
    wr(12'h008, 18'h0_0001);
    ack;
    quiet;
    @(posedge hclk) pwr_fail_req <= 1'b1;
    quiet;
    // power-down condition goes to the unmaskable input
    @(posedge hclk) {rst_hi_req, mains_fail_signal} <= 2'h3;
    offer(16'h0024, 3'h0);
    @(posedge hclk) rst_hi_req <= 1'b0;
    ack;
    quiet;
    rd("status", 12'h000, 18'h0_0005);
    wr(12'h004, 18'h0_0001);
    @(negedge hclk) chk("irq", {31'h0, irq}, 32'h0000_0001);
    wr(12'h000, 18'h0_0007);
    @(negedge hclk) chk("irq", {31'h0, irq}, 32'h0000_0000);
    $display("test direct inputs done");
    @(posedge hclk) ack_wait <= 4'h0;
    for (i = 0; i < 7; i++) wr(12'h020 + 12'(i * 4), 18'h0_0001 << i);
    wr(12'h03C, 18'h2_0000);
    wr(12'h368, 18'h0_00B4);
    wr(12'h36C, 18'h0_0012);
    wr(12'h36C, 18'h0_0000);
    rd("level mask", 12'h36C, 18'h0_0000);
    raise(18'h0_0024);
    offer(16'h12A8, 3'h4);
    ack;
    quiet;
    wr(12'h368, 18'h0_000B);
    rd("in service", 12'h368, 18'h0_0004);
    wr(12'h368, 18'h0_000A);
    rd("requests", 12'h368, 18'h0_0020);
    @(posedge hclk) src_req <= 18'h0_0026;
    offer(16'h12A4, 3'h4);
    ack;
    wr(12'h368, 18'h0_0020);
    quiet;
    wr(12'h368, 18'h0_0020);
    offer(16'h12B4, 3'h4);
    serve;
    raise(18'h0_0001);
    rst_mid_req <= 1'b1;
    offer(16'h0034, 3'h2);
    @(posedge hclk) rst_mid_req <= 1'b0;
    ack;
    offer(16'h12A0, 3'h4);
    serve;
    wr(12'h36C, 18'h0_0008);
    raise(18'h0_0008);
    quiet;
    wr(12'h36C, 18'h0_0000);
    offer(16'h12AC, 3'h4);
    serve;
    raise(18'h2_0000);
    offer(16'h12BC, 3'h4);
    serve;
    $display("test nested done");
    wr(12'h368, 18'h0_00B0);
    wr(12'h36C, 18'h0_0012);
    wr(12'h36C, 18'h0_0000);
    raise(18'h0_0008);
    offer(16'h1298, 3'h4);
    serve;
    wr(12'h368, 18'h0_0040);
    raise(18'h0_0001);
    offer(16'h1280, 3'h4);
    serve;
    raise(18'h0_0003);
    offer(16'h1288, 3'h4);
    serve;
    offer(16'h1280, 3'h4);
    serve;
    wr(12'h368, 18'h0_00C3);
    raise(18'h0_0024);
    offer(16'h12A8, 3'h4);
    serve;
    offer(16'h1290, 3'h4);
    serve;
    wr(12'h368, 18'h0_0080);
    raise(18'h0_0040);
    quiet;
    rd("poll", 12'h368, 18'h0_0086);
    bus(1'b0, 12'h368, 18'h0_0000);
    chk("poll empty", rdat & 32'h0000_0080, 32'h0000_0000);
    wr(12'h368, 18'h0_0020);
    wr(12'h368, 18'h0_0000);
    $display("test modes done");
    final_report;
  end
endmodule
`default_nettype wire
